// file: hdl/tws_pkg.sv
// Constants and types for the three-wire serial memory access block.
// Assumes a single 20 MHz system clock; no software registers.
package tws_pkg;

   // ==========================================================
   // Clock and timing
   localparam int unsigned CLOCK_HZ          = 20_000_000;
   localparam int unsigned WRITE_TIME_US     = 10_000;      // Longest self-timed write, 10 ms
   // Longest time rounds down to whole cycles
   localparam int unsigned WRITE_CYCLES      = (CLOCK_HZ / 1_000_000) * WRITE_TIME_US;

   // ==========================================================
   // Serial framing: start bit, two opcode bits, address, data
   localparam int unsigned OPCODE_BITS       = 2;
   localparam logic [1:0]  OP_EXTENDED       = 2'h0;
   localparam logic [1:0]  OP_WRITE          = 2'h1;
   localparam logic [1:0]  OP_READ           = 2'h2;
   localparam logic [1:0]  OP_ERASE          = 2'h3;
   // Extended sub-codes sit in the two top address bits
   localparam logic [1:0]  EXT_DISABLE       = 2'h0;
   localparam logic [1:0]  EXT_WRITE_ALL     = 2'h1;
   localparam logic [1:0]  EXT_ERASE_ALL     = 2'h2;
   localparam logic [1:0]  EXT_ENABLE        = 2'h3;

   // ==========================================================
   // Reset values
   localparam logic        WRITE_ENABLE_RST  = 1'b0;      // Writes locked after reset
   localparam logic        ERASED_BIT        = 1'b1;      // Erase leaves ones

   // ==========================================================
   // Control states, one-hot
   typedef enum logic [5:0] {
      TWS_IDLE   = 6'h01,
      TWS_OPCODE = 6'h02,
      TWS_ADDR   = 6'h04,
      TWS_RDATA  = 6'h08,
      TWS_WDATA  = 6'h10,
      TWS_DONE   = 6'h20
   } tws_state_type;

endpackage

// file: hdl/tws_sync.sv
// Two-flop synchroniser for the pin inputs of the serial memory block.
// Assumes pins change asynchronously to clock.
`timescale 1ns/10ps
`default_nettype none
module tws_sync
   import tws_pkg::*;
#(
   parameter int unsigned WIDTH = 1
)
(
   input  wire logic             clock,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] pin_in,
   output var  logic [WIDTH-1:0] pin_out
);

   typedef struct packed
   {
      logic [WIDTH-1:0] first_reg;
      logic [WIDTH-1:0] second_reg;
   } tws_sync_type;

   tws_sync_type st_reg;
   tws_sync_type st_next;

   // ==========================================================
   // Shift chain; only the second stage is visible
   always_comb
   begin
      st_next.first_reg  = pin_in;
      st_next.second_reg = st_reg.first_reg;
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign pin_out = st_reg.second_reg;

endmodule
`default_nettype wire

// file: hdl/tws_memory.sv
// Device side of a three-wire serial non-volatile memory.
// Assumes the host link pins arrive asynchronously; one 20 MHz clock.
// How it works
// - Size 64/128/256 x16 or double x8
// - Strap high selects x16, low x8
// - Reset starts x16; idle then follows the strap
// - Low-voltage variant ignores the strap
// - Link active only while chip select high
// - Read shifts addressed word out serially
// - Self-timed write ends within 10 ms
// - Write overwrites without a prior erase
// - Writes only while write enable active
// - Select after write drives ready/busy out
`timescale 1ns/10ps
`default_nettype none
module tws_memory
   import tws_pkg::*;
#(
   parameter int unsigned WORDS16      = 64,            // Density: 64, 128 or 256
   parameter bit          LOW_VOLTAGE  = 1'b0,          // Variant without organisation choice
   parameter int unsigned WRITE_CYCLES_P = WRITE_CYCLES // Shorten in simulation
)
(
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic chip_select,
   input  wire logic shift_clock_in,
   input  wire logic serial_in,
   input  wire logic word_width_strap,
   output var  logic serial_out,
   output var  logic serial_out_en_n,
   output var  logic write_busy
);

   localparam int unsigned BYTES  = 2 * WORDS16;
   localparam int unsigned AW8    = $clog2(BYTES);      // x8 address width
   localparam int unsigned AW16   = AW8 - 1;            // x16 address width
   localparam int unsigned CW     = $clog2(WRITE_CYCLES_P + 1);

   // Elaboration checks: only the three densities are decoded
   if (!(WORDS16 == 64 || WORDS16 == 128 || WORDS16 == 256))
   begin : g_bad_words
      $error("WORDS16 must be 64, 128 or 256");
   end
   // A zero write time would leave the timer width CW at zero
   if (WRITE_CYCLES_P < 1)
   begin : g_bad_cycles
      $error("WRITE_CYCLES_P must be at least 1");
   end

   typedef struct packed
   {
      tws_state_type   state_reg;
      logic            sk_prev_reg;
      logic            wide_reg;                 // Latched organisation
      logic            wen_reg;                  // Erase/write enable state
      logic [1:0]      op_reg;
      logic [AW8-1:0]  addr_reg;
      logic [4:0]      count_reg;
      logic [15:0]     shift_reg;
      logic            dout_reg;
      logic            drive_reg;
      logic            busy_reg;
      logic [CW-1:0]   timer_reg;
      logic            pend_reg;                 // Write waiting to start
      logic            pend_all_reg;
      logic            pend_erase_reg;
      logic [AW8-1:0]  pend_addr_reg;
      logic [15:0]     pend_data_reg;
      logic [BYTES*8-1:0] mem_reg;
   } tws_mem_type;

   tws_mem_type st_reg;
   tws_mem_type st_next;
   logic        cs_s;
   logic        sk_s;
   logic        di_s;
   logic        org_s;

   // ==========================================================
   // Pin synchronisers
   tws_sync #(.WIDTH(4)) u_sync
   (
      .clock   (clock),
      .rst_n   (rst_n),
      .pin_in  ({chip_select, shift_clock_in, serial_in, word_width_strap}),
      .pin_out ({cs_s, sk_s, di_s, org_s})
   );

   // Address bits expected for the current organisation
   function automatic logic [4:0] addr_bits(input logic wide);
      addr_bits = wide ? 5'(AW16) : 5'(AW8);
   endfunction

   // Data bits per word for the current organisation
   function automatic logic [4:0] data_bits(input logic wide);
      data_bits = wide ? 5'h10 : 5'h08;
   endfunction

   // Read a word; x16 word n holds bytes 2n (high) and 2n+1
   function automatic logic [15:0] rd_word(input logic [BYTES*8-1:0] m, input logic wide,
                                           input logic [AW8-1:0] a);
      logic [AW8-1:0] b;
      b = wide ? AW8'({a[AW8-2:0], 1'b0}) : a;
      if (wide)
         rd_word = {m[b*8 +: 8], m[(b+1)*8 +: 8]};
      else
         rd_word = {m[b*8 +: 8], 8'h00};
   endfunction

   // ==========================================================
   // Protocol and write engine
   always_comb
   begin
      logic rise;
      logic [4:0] nbits;
      logic [AW8-1:0] b;
      rise  = 1'b0;
      nbits = 5'h00;
      b     = '0;
      st_next = st_reg;
      st_next.sk_prev_reg = sk_s;
      rise = sk_s && !st_reg.sk_prev_reg;
      // Strap sampled while idle; variant without choice stays x16
      if (st_reg.state_reg == TWS_IDLE)
         st_next.wide_reg = LOW_VOLTAGE ? 1'b1 : org_s;

      // Self-timed write countdown
      if (st_reg.busy_reg)
      begin
         if (st_reg.timer_reg <= CW'(1))
            st_next.busy_reg = 1'b0;
         else
            st_next.timer_reg = st_reg.timer_reg - CW'(1);
      end
      else if (st_reg.pend_reg)
      begin
         st_next.pend_reg  = 1'b0;
         st_next.busy_reg  = 1'b1;
         st_next.timer_reg = CW'(WRITE_CYCLES_P);
         for (int i = 0; i < BYTES; i++)
         begin
            b = AW8'(i);
            if (st_reg.pend_all_reg)
               st_next.mem_reg[i*8 +: 8] = st_reg.pend_erase_reg ? {8{ERASED_BIT}}
                                           : (st_reg.wide_reg ? (b[0] ? st_reg.pend_data_reg[7:0]
                                           : st_reg.pend_data_reg[15:8]) : st_reg.pend_data_reg[15:8]);
         end
         if (!st_reg.pend_all_reg)
         begin
            // Direct overwrite, no erase needed first
            b = st_reg.wide_reg ? AW8'({st_reg.pend_addr_reg[AW8-2:0], 1'b0}) : st_reg.pend_addr_reg;
            st_next.mem_reg[b*8 +: 8] = st_reg.pend_erase_reg ? {8{ERASED_BIT}}
                                        : st_reg.pend_data_reg[15:8];
            if (st_reg.wide_reg)
               st_next.mem_reg[(b+1)*8 +: 8] = st_reg.pend_erase_reg ? {8{ERASED_BIT}}
                                               : st_reg.pend_data_reg[7:0];
         end
      end

      nbits = addr_bits(st_reg.wide_reg);
      if (!cs_s)
      begin
         // Deselect aborts any frame and floats the output
         st_next.state_reg = TWS_IDLE;
         st_next.drive_reg = 1'b0;
         st_next.count_reg = 5'h00;
      end
      else
      begin
         st_next.drive_reg = 1'b1;
         case (st_reg.state_reg)
            TWS_IDLE:
            begin
               // Ready/busy shown until the start bit
               st_next.dout_reg = !(st_reg.busy_reg || st_reg.pend_reg);
               if (rise && di_s && !st_reg.busy_reg && !st_reg.pend_reg)
               begin
                  st_next.state_reg = TWS_OPCODE;
                  st_next.count_reg = 5'h00;
               end
            end
            TWS_OPCODE:
               if (rise)
               begin
                  st_next.op_reg = {st_reg.op_reg[0], di_s};
                  st_next.count_reg = st_reg.count_reg + 5'h01;
                  if (st_reg.count_reg == 5'(OPCODE_BITS - 1))
                  begin
                     st_next.state_reg = TWS_ADDR;
                     st_next.count_reg = 5'h00;
                  end
               end
            TWS_ADDR:
               if (rise)
               begin
                  st_next.addr_reg = {st_reg.addr_reg[AW8-2:0], di_s};
                  st_next.count_reg = st_reg.count_reg + 5'h01;
                  if (st_reg.count_reg == nbits - 5'h01)
                  begin
                     st_next.count_reg = 5'h00;
                     case (st_reg.op_reg)
                        OP_READ:
                        begin
                           // Decode address, dummy zero then data MSB first
                           st_next.shift_reg = rd_word(st_reg.mem_reg, st_reg.wide_reg,
                                                       {st_reg.addr_reg[AW8-2:0], di_s});
                           st_next.dout_reg  = 1'b0;
                           st_next.state_reg = TWS_RDATA;
                        end
                        OP_WRITE:
                           st_next.state_reg = TWS_WDATA;
                        OP_ERASE:
                        begin
                           st_next.pend_reg       = st_reg.wen_reg;
                           st_next.pend_all_reg   = 1'b0;
                           st_next.pend_erase_reg = 1'b1;
                           st_next.pend_addr_reg  = {st_reg.addr_reg[AW8-2:0], di_s};
                           st_next.state_reg      = TWS_DONE;
                        end
                        default:
                        begin
                           // Extended: sub-code in two top address bits
                           case (nbits == 5'(AW8) ? st_reg.addr_reg[AW8-2:AW8-3]
                                                  : st_reg.addr_reg[AW16-2:AW16-3])
                              EXT_ENABLE:    st_next.wen_reg = 1'b1;
                              EXT_DISABLE:   st_next.wen_reg = 1'b0;
                              EXT_ERASE_ALL:
                              begin
                                 st_next.pend_reg       = st_reg.wen_reg;
                                 st_next.pend_all_reg   = 1'b1;
                                 st_next.pend_erase_reg = 1'b1;
                              end
                              default:
                                 st_next.op_reg = OP_EXTENDED;
                           endcase
                           st_next.state_reg = (st_next.op_reg == OP_EXTENDED
                                                && st_reg.addr_reg[AW16-2:AW16-3] == EXT_WRITE_ALL
                                                && nbits == 5'(AW16))
                                               || (nbits == 5'(AW8)
                                                && st_reg.addr_reg[AW8-2:AW8-3] == EXT_WRITE_ALL)
                                               ? TWS_WDATA : TWS_DONE;
                        end
                     endcase
                  end
               end
            TWS_RDATA:
               if (rise)
               begin
                  st_next.dout_reg  = st_reg.shift_reg[15];
                  st_next.shift_reg = {st_reg.shift_reg[14:0], 1'b0};
                  st_next.count_reg = st_reg.count_reg + 5'h01;
                  if (st_reg.count_reg == data_bits(st_reg.wide_reg) - 5'h01)
                     st_next.state_reg = TWS_DONE;
               end
            TWS_WDATA:
               if (rise)
               begin
                  st_next.shift_reg = {st_reg.shift_reg[14:0], di_s};
                  st_next.count_reg = st_reg.count_reg + 5'h01;
                  if (st_reg.count_reg == data_bits(st_reg.wide_reg) - 5'h01)
                  begin
                     st_next.pend_reg       = st_reg.wen_reg;
                     st_next.pend_all_reg   = (st_reg.op_reg == OP_EXTENDED);
                     st_next.pend_erase_reg = 1'b0;
                     st_next.pend_addr_reg  = st_reg.addr_reg;
                     st_next.pend_data_reg  = st_reg.wide_reg ? {st_reg.shift_reg[14:0], di_s}
                                                              : {st_reg.shift_reg[6:0], di_s, 8'h00};
                     st_next.state_reg      = TWS_DONE;
                  end
               end
            TWS_DONE:
               // Extra clocks are ignored until deselect
               st_next.state_reg = TWS_DONE;
            default:
               st_next.state_reg = TWS_IDLE;
         endcase
      end
   end

   // ==========================================================
   // State register; memory powers up erased
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_reg           <= '0;
         st_reg.state_reg <= TWS_IDLE;
         st_reg.wide_reg  <= 1'b1;
         st_reg.wen_reg   <= WRITE_ENABLE_RST;
         st_reg.mem_reg   <= {(BYTES*8){ERASED_BIT}};
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // Outputs from flip-flops
   assign serial_out      = st_reg.dout_reg;
   assign serial_out_en_n = !st_reg.drive_reg;
   assign write_busy      = st_reg.busy_reg;

endmodule
`default_nettype wire

// file: bench/tws_memory_chk.sv
// Port checker for the serial memory block.
// Bound to every tws_memory instance; sees its ports only.
`timescale 1ns/10ps
`default_nettype none
module tws_memory_chk
#(
   parameter int unsigned WRITE_CYCLES_P = 20
)
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic chip_select,
   input wire logic shift_clock_in,
   input wire logic serial_out,
   input wire logic serial_out_en_n,
   input wire logic write_busy
);
   // ==========================================
   // Busy length counter and properties
   logic [31:0] busy_cnt_reg;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);

   // Counts consecutive busy cycles
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         busy_cnt_reg <= 32'h0;
      else
         busy_cnt_reg <= write_busy ? busy_cnt_reg + 32'h1 : 32'h0;
   end

   reset_quiet_a: assert property ($rose(rst_n) |-> serial_out_en_n && !write_busy)
      else $error("outputs active after reset");
   release_line_a: assert property ((!chip_select)[*4] |-> serial_out_en_n)
      else $error("output driven while deselected");
   self_timed_a: assert property ($fell(write_busy) |-> busy_cnt_reg == WRITE_CYCLES_P)
      else $error("write time wrong");
   busy_bound_a: assert property (busy_cnt_reg <= WRITE_CYCLES_P)
      else $error("write runs too long");
   busy_status_a: assert property (
      (!chip_select)[*4] ##1 chip_select[*5] ##0 write_busy |-> !serial_out_en_n && !serial_out)
      else $error("busy status not low");
   start_selected_a: assert property ($rose(write_busy) |-> $past(chip_select, 3))
      else $error("write began unselected");
   out_moves_a: assert property (
      !serial_out_en_n && $past(!serial_out_en_n) && $changed(serial_out)
      |-> $past(shift_clock_in, 3) || write_busy || $past(write_busy) || $past(write_busy, 2))
      else $error("output moved without shift clock");
   drive_selected_a: assert property ($fell(serial_out_en_n) |-> $past(chip_select, 2) && chip_select)
      else $error("output enabled without select");

   cover property ($rose(write_busy));
   cover property ($fell(serial_out_en_n));
   cover property (write_busy && !serial_out_en_n);
endmodule

bind tws_memory tws_memory_chk #(.WRITE_CYCLES_P(WRITE_CYCLES_P)) u_chk (
   .clock(clock),
   .rst_n(rst_n),
   .chip_select(chip_select),
   .shift_clock_in(shift_clock_in),
   .serial_out(serial_out),
   .serial_out_en_n(serial_out_en_n),
   .write_busy(write_busy)
);
`default_nettype wire

// file: bench/tws_host_model.sv
// Host serial controller model: select, shift clock and data.
// Assumes the bench calls its tasks; drives only at clock rising edges after the time-zero idle levels.
`timescale 1ns/10ps
`default_nettype none
module tws_host_model
(
   input  wire logic clock,
   input  wire logic serial_out,
   input  wire logic serial_out_en_n,
   output var  logic chip_select,
   output var  logic shift_clock_in,
   output var  logic serial_in
);
   // ==========================================
   // Data line and transfer tasks
   localparam int HALF = 6;  // Clocks per shift clock high phase; the low phase is twice this
   logic last_q;
   logic line;

   // Released line shows the inverse of its last driven level
   always_ff @(posedge clock)
      if (!serial_out_en_n)
         last_q <= serial_out;
   assign line = serial_out_en_n ? ~last_q : serial_out;

   // Idle pins at time zero
   initial
   begin
      chip_select = 1'b0;
      shift_clock_in = 1'b0;
      serial_in = 1'b0;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(posedge clock);
   endtask

   // Select, shift n bits, collect one bit after each rise, deselect
   task automatic frame(input logic [31:0] bits, input int n, output logic [31:0] got);
      got = 32'h0;
      chip_select <= 1'b1;
      for (int i = n - 1; i >= 0; i--)
      begin
         wait_clk(HALF);
         serial_in <= bits[i];
         wait_clk(HALF);
         shift_clock_in <= 1'b1;
         wait_clk(HALF);
         got = {got[30:0], line};
         shift_clock_in <= 1'b0;
      end
      wait_clk(HALF);
      chip_select <= 1'b0;
      serial_in <= ~serial_in;  // Stale data not kept
      wait_clk(2 * HALF);
   endtask

   // Select without clocking and read the status level
   task automatic status(output logic v);
      chip_select <= 1'b1;
      wait_clk(HALF);
      v = line;
      chip_select <= 1'b0;
      wait_clk(2 * HALF);
   endtask
endmodule
`default_nettype wire

// file: bench/tws_memory_bench.sv
// Testbench for the serial memory block through the host model.
// Assumes the design, host model and bound checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
module tws_memory_bench;
   // ==========================================
   // Signals, instances and scenarios
   localparam int unsigned WC = 60;  // Shortened write time
   logic clock, rst_n, strap, cs, sk, si, so, so_en_n, busy;
   int   err_count;
   int   compares;

   tws_memory #(.WRITE_CYCLES_P(WC)) dut (
      .clock(clock), .rst_n(rst_n), .chip_select(cs), .shift_clock_in(sk),
      .serial_in(si), .word_width_strap(strap), .serial_out(so),
      .serial_out_en_n(so_en_n), .write_busy(busy));
   tws_host_model u_host (
      .clock(clock), .serial_out(so), .serial_out_en_n(so_en_n),
      .chip_select(cs), .shift_clock_in(sk), .serial_in(si));

   // 20 MHz clock
   initial
   begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   task automatic stop_test;
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Enable or disable writes; sub-code in top address bits
   task automatic ext(input logic [1:0] sub);
      logic [31:0] g;
      u_host.frame(32'({3'b100, sub, 4'h0}), 9, g);
   endtask

   // Write, then status shows low at once if the write takes, and high within a bound
   task automatic wr(input int aw, input int dw, input logic [15:0] a, input logic [15:0] d,
                     input logic takes);
      logic [31:0] g;
      logic        v;
      u_host.frame((32'h5 << (aw + dw)) | (32'(a) << dw) | 32'(d), 3 + aw + dw, g);
      u_host.status(v);
      check("write status", {31'h0, !takes}, {31'h0, v});
      for (int i = 0; i < 20 && v !== 1'b1; i++)
         u_host.status(v);
      if (v !== 1'b1)
      begin
         err_count++;
         $display("[ERR] ready status expected 1 seen %b", v);
         stop_test();
      end
   endtask

   // Read: dummy zero then the word, MSB first
   task automatic rd(input int aw, input int dw, input logic [15:0] a, input logic [15:0] exp);
      logic [31:0] g;
      u_host.frame((32'h6 << (aw + dw)) | (32'(a) << dw), 3 + aw + dw, g);
      check("read data", 32'(exp), g & ((32'h2 << dw) - 32'h1));
   endtask

   task automatic t_locked;
      rd(6, 16, 16'h00, 16'hFFFF);
      wr(6, 16, 16'h07, 16'h1234, 1'b0);
      rd(6, 16, 16'h07, 16'hFFFF);
   endtask

   task automatic t_overwrite;
      ext(2'h3);
      wr(6, 16, 16'h3F, 16'hA55A, 1'b1);
      wr(6, 16, 16'h3F, 16'h5AA5, 1'b1);
      rd(6, 16, 16'h3F, 16'h5AA5);
   endtask

   task automatic t_narrow;
      strap <= 1'b0;
      u_host.wait_clk(4);
      rd(7, 8, 16'h7E, 16'h5A);
      rd(7, 8, 16'h7F, 16'hA5);
      wr(7, 8, 16'h7F, 16'h3C, 1'b1);
      strap <= 1'b1;
      u_host.wait_clk(4);
      rd(6, 16, 16'h3F, 16'h5A3C);
   endtask

   task automatic t_disable;
      ext(2'h0);
      wr(6, 16, 16'h3F, 16'h0000, 1'b0);
      rd(6, 16, 16'h3F, 16'h5A3C);
   endtask

   // Main sequence
   initial
   begin
      err_count = 0;
      compares = 0;
      rst_n = 1'b0;
      strap = 1'b1;
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      repeat (3) @(posedge clock);
      t_locked();
      t_overwrite();
      t_narrow();
      t_disable();
      stop_test();
   end
endmodule
`default_nettype wire
